//--- hdl/spsc_state_ctrl.sv
// Security and privilege state control with access gating
`timescale 1ns/1ps
`default_nettype none
module spsc_state_ctrl import spsc_pkg::*; #(
    parameter int ENTRIES = TLB_ENTRIES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire spsc_event_type event_in,
    input wire spsc_access_type access_in,
    input wire spsc_tlb_fill_type tlb_fill_in,
    input wire logic tlb_flush_in,
    input wire logic ctrl_we_in,
    input wire logic [CTRL_WIDTH-1:0] ctrl_wdata_in,
    input wire logic ttb_we_in,
    input wire logic [63:0] ttb_wdata_in,
    input wire logic instr_valid_in,
    input wire logic instr_need_secure_in,
    input wire logic instr_need_root_in,
    input wire logic instr_need_sup_in,
    output spsc_level_type level_out,
    output logic secure_out,
    output logic [CTRL_WIDTH-1:0] ctrl_rdata_out,
    output logic [63:0] ttb_out,
    output spsc_mem_req_type mem_req_out,
    output logic instr_allow_out,
    output logic fault_out,
    output spsc_fault_type fault_code_out
);
    spsc_level_type level_q, level_d;
    logic [CTRL_WIDTH-1:0] ctrl_bank_q [NUM_LEVELS];
    logic [63:0] ttb_bank_q [NUM_LEVELS];
    spsc_mem_req_type mem_q, mem_d;
    logic fault_q, fault_d;
    spsc_fault_type code_q, code_d;

    wire cur_sec = lvl_secure(level_q);
    wire cur_root = lvl_root(level_q);
    wire cur_sup = lvl_sup(level_q);
    wire tgt_sec = lvl_secure(event_in.target);
    wire tgt_root = lvl_root(event_in.target);
    wire ev_ret = event_in.valid && event_in.kind == EV_RETURN;
    wire ev_hdl = event_in.valid && event_in.kind == EV_HANDLER;
    wire ev_scall = event_in.valid && event_in.kind == EV_SECURE_CALL;
    wire ev_rcall = event_in.valid && event_in.kind == EV_ROOT_CALL;

    // Only a supervisor may return, and only downward in privilege
    wire leave_sec = cur_sec && !tgt_sec;
    wire leave_root = cur_root && !tgt_root;
    wire ok_leave_sec = ev_ret && level_q == LVL_S_ROOT_SUP;
    wire ok_leave_root = ev_ret && cur_root && cur_sup;
    wire enter_sec = !cur_sec && tgt_sec;
    wire enter_root = !cur_root && tgt_root;
    // Secure entry always lands in secure root supervisor
    wire ok_enter_sec = (ev_hdl || ev_scall) &&
                        event_in.target == LVL_S_ROOT_SUP;
    wire ok_enter_root = (ev_hdl && event_in.target == LVL_N_ROOT_SUP) ||
                         (ev_rcall && event_in.target == LVL_N_ROOT_SUP) ||
                         ok_enter_sec;
    wire ret_from_user = ev_ret && !cur_sup;
    wire call_wrong = (ev_scall && event_in.target != LVL_S_ROOT_SUP) ||
                      (ev_rcall && !tgt_root);
    wire kind_bad = event_in.valid && event_in.kind != EV_NONE &&
                    !(ev_ret || ev_hdl || ev_scall || ev_rcall);
    wire tgt_bad = event_in.valid && event_in.target > LVL_N_GST_USR;
    wire change_bad = event_in.valid && event_in.kind != EV_NONE &&
        ((leave_sec && !ok_leave_sec) || (leave_root && !ok_leave_root) ||
         (enter_sec && !ok_enter_sec) || (enter_root && !ok_enter_root) ||
         ret_from_user || call_wrong || kind_bad || tgt_bad);
    wire change_ok = event_in.valid && event_in.kind != EV_NONE &&
                     !change_bad;

    // Refused changes leave the level untouched
    always_comb begin
        level_d = level_q;
        if (change_ok) begin
            level_d = event_in.target;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_q <= LEVEL_RESET;
        end else begin
            level_q <= level_d;
        end
    end

    // Banked copies; writes and reads only touch the current level
    genvar g;
    generate
        for (g = 0; g < NUM_LEVELS; g++) begin : g_bank
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ctrl_bank_q[g] <= CTRL_RESET;
                    ttb_bank_q[g] <= TTB_RESET;
                end else if (level_q == spsc_level_type'(g)) begin
                    if (ctrl_we_in) begin
                        ctrl_bank_q[g] <= ctrl_wdata_in;
                    end
                    if (ttb_we_in) begin
                        ttb_bank_q[g] <= ttb_wdata_in;
                    end
                end
            end
        end
    endgenerate

    assign ctrl_rdata_out = ctrl_bank_q[level_q];
    assign ttb_out = ttb_bank_q[level_q];

    logic tlb_hit;
    spsc_tlb_fill_type tlb_ent;

    // Context tag is the level code, so translations never cross levels
    spsc_micro_tlb #(.ENTRIES(ENTRIES)) u_tlb (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .flush_in(tlb_flush_in),
        .fill_in(tlb_fill_in),
        .ctx_in(level_q),
        .vpn_in(access_in.vaddr[VA_WIDTH-1:PAGE_SHIFT]),
        .hit_out(tlb_hit),
        .entry_out(tlb_ent)
    );

    wire sec_bad = tlb_ent.secure && !cur_sec;
    wire perm_bad = (!cur_sup && !tlb_ent.user_ok) ||
                    (access_in.write && !tlb_ent.write_ok) ||
                    (access_in.exec && !tlb_ent.exec_ok);
    wire attr_bad = tlb_ent.attr == ATTR_ILLEGAL ||
                    (access_in.exec && tlb_ent.attr[3]);

    // Check order gives a single precise cause per access
    always_comb begin
        mem_d = '0;
        fault_d = 1'b0;
        code_d = FLT_NONE;
        if (event_in.valid && change_bad) begin
            fault_d = 1'b1;
            code_d = FLT_LEVEL;
        end else if (access_in.valid) begin
            fault_d = 1'b1;
            if (!tlb_hit) begin
                code_d = FLT_TLB_MISS;
            end else if (sec_bad) begin
                code_d = FLT_SECURE;
            end else if (perm_bad) begin
                code_d = FLT_PERM;
            end else if (attr_bad) begin
                code_d = FLT_ATTR;
            end else begin
                fault_d = 1'b0;
                mem_d.valid = 1'b1;
                mem_d.write = access_in.write;
                mem_d.secure = tlb_ent.secure;
                mem_d.attr = tlb_ent.attr;
                mem_d.paddr = {tlb_ent.ppn,
                    access_in.vaddr[PAGE_SHIFT-1:0]};
            end
        end else if (instr_valid_in && !instr_allow_out) begin
            fault_d = 1'b1;
            code_d = FLT_INSTR;
        end
    end

    assign instr_allow_out = (!instr_need_secure_in || cur_sec) &&
                             (!instr_need_root_in || cur_root) &&
                             (!instr_need_sup_in || cur_sup);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_q <= '0;
            fault_q <= 1'b0;
            code_q <= FLT_NONE;
        end else begin
            mem_q <= mem_d;
            fault_q <= fault_d;
            code_q <= code_d;
        end
    end

    assign level_out = level_q;
    assign secure_out = cur_sec;
    assign mem_req_out = mem_q;
    assign fault_out = fault_q;
    assign fault_code_out = code_q;

    AST_NS_NO_SECURE: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        mem_req_out.valid && mem_req_out.secure |-> $past(cur_sec))
        else $error("Non-secure level reached secure memory");

    AST_SEC_ACCESS: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        access_in.valid && cur_sec && tlb_hit && !perm_bad && !attr_bad
        && !(event_in.valid && change_bad) |=> mem_req_out.valid)
        else $error("Secure access was not issued");

    AST_LEAVE_SEC: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        lvl_secure($past(level_q)) && !secure_out |->
        $past(level_q) == LVL_S_ROOT_SUP && $past(ev_ret))
        else $error("Left secure state on an illegal path");

    AST_LEAVE_ROOT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        lvl_root($past(level_q)) && !lvl_root(level_q) |->
        $past(ev_ret) && lvl_sup($past(level_q)))
        else $error("Left root level on an illegal path");

    AST_ENTER_SEC: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !lvl_secure($past(level_q)) && secure_out |->
        $past(ev_hdl) || $past(ev_scall))
        else $error("Entered secure state on an illegal path");

    AST_ENTER_ROOT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !lvl_root($past(level_q)) && lvl_root(level_q) |->
        $past(ev_hdl) || $past(ev_rcall) || $past(ev_scall))
        else $error("Entered root level on an illegal path");

    AST_BAD_CHANGE_FAULT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        change_bad |=> fault_out && fault_code_out == FLT_LEVEL &&
        level_q == $past(level_q))
        else $error("Illegal level change not blocked");

    AST_PADDR: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        mem_req_out.valid |-> mem_req_out.paddr[PAGE_SHIFT-1:0] ==
        $past(access_in.vaddr[PAGE_SHIFT-1:0]))
        else $error("Page offset not carried into physical address");

    AST_MISS_FAULT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        access_in.valid && !tlb_hit && !change_bad |=>
        fault_out && fault_code_out == FLT_TLB_MISS && !mem_req_out.valid)
        else $error("Untranslated access not faulted");

    AST_INSTR: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        instr_allow_out && instr_need_secure_in |-> secure_out)
        else $error("Secure-only instruction allowed outside secure");

    AST_LEVEL_LEGAL: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        level_out <= LVL_N_GST_USR)
        else $error("Level left the six legal codes");

    AST_NS_SEC_FAULT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        access_in.valid && tlb_hit && tlb_ent.secure && !cur_sec &&
        !(event_in.valid && change_bad) |=>
        fault_out && fault_code_out == FLT_SECURE && !mem_req_out.valid)
        else $error("Secure target reached from non-secure level");

    AST_USER_PERM: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        access_in.valid && tlb_hit && !cur_sup && !tlb_ent.user_ok &&
        !(event_in.valid && change_bad) |=> fault_out && !mem_req_out.valid)
        else $error("User level used a supervisor-only page");

    AST_GRANT_ATTR: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        mem_req_out.valid |-> mem_req_out.attr != ATTR_ILLEGAL)
        else $error("Access granted with an illegal attribute");

    AST_INSTR_FAULT: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        instr_valid_in && !instr_allow_out && !access_in.valid &&
        !(event_in.valid && change_bad) |=>
        fault_out && fault_code_out == FLT_INSTR)
        else $error("Refused instruction raised no fault");

    AST_CTRL_WRITE: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        ctrl_we_in && level_d == level_q |=>
        ctrl_rdata_out == $past(ctrl_wdata_in))
        else $error("Control write not seen by its own level");

    AST_CTRL_KEEP: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !ctrl_we_in && level_d == level_q |=> $stable(ctrl_rdata_out))
        else $error("Control copy changed without a write");

    AST_TTB_WRITE: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        ttb_we_in && level_d == level_q |=> ttb_out == $past(ttb_wdata_in))
        else $error("Table base write not seen by its own level");
endmodule
`default_nettype wire

//--- hdl/spsc_pkg.sv
// Package: levels, events, access carriers and micro-TLB sizing
package spsc_pkg;

    // Six privilege and execution levels, binary coded
    typedef enum logic [2:0] {
        LVL_S_ROOT_SUP = 3'h0,
        LVL_S_ROOT_USR = 3'h1,
        LVL_N_ROOT_SUP = 3'h2,
        LVL_N_ROOT_USR = 3'h3,
        LVL_N_GST_SUP  = 3'h4,
        LVL_N_GST_USR  = 3'h5
    } spsc_level_type;

    localparam int NUM_LEVELS = 6;
    localparam spsc_level_type LEVEL_RESET = LVL_S_ROOT_SUP;

    localparam int VA_WIDTH = 64;
    localparam int PA_WIDTH = 40;
    localparam int PAGE_SHIFT = 12;
    localparam int VPN_WIDTH = VA_WIDTH - PAGE_SHIFT;
    localparam int PPN_WIDTH = PA_WIDTH - PAGE_SHIFT;
    localparam int TLB_ENTRIES = 8;
    localparam int CTRL_WIDTH = 32;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [63:0] TTB_RESET = 64'h0000_0000_0000_0000;

    // Kinds of level-changing event from the pipeline
    typedef enum logic [2:0] {
        EV_NONE        = 3'h0,
        EV_RETURN      = 3'h1,
        EV_HANDLER     = 3'h2,
        EV_SECURE_CALL = 3'h3,
        EV_ROOT_CALL   = 3'h4
    } spsc_event_kind_type;

    typedef struct packed {
        logic valid;
        spsc_event_kind_type kind;
        spsc_level_type target;
    } spsc_event_type;

    // Memory access from the processor
    typedef struct packed {
        logic valid;
        logic write;
        logic exec;
        logic [VA_WIDTH-1:0] vaddr;
    } spsc_access_type;

    // One micro-TLB fill
    typedef struct packed {
        logic valid;
        logic [VPN_WIDTH-1:0] vpn;
        logic [PPN_WIDTH-1:0] ppn;
        logic secure;
        logic user_ok;
        logic write_ok;
        logic exec_ok;
        logic [3:0] attr;
    } spsc_tlb_fill_type;

    // Answer to the memory system
    typedef struct packed {
        logic valid;
        logic write;
        logic secure;
        logic [3:0] attr;
        logic [PA_WIDTH-1:0] paddr;
    } spsc_mem_req_type;

    typedef enum logic [2:0] {
        FLT_NONE      = 3'h0,
        FLT_TLB_MISS  = 3'h1,
        FLT_SECURE    = 3'h2,
        FLT_PERM      = 3'h3,
        FLT_ATTR      = 3'h4,
        FLT_LEVEL     = 3'h5,
        FLT_INSTR     = 3'h6
    } spsc_fault_type;

    localparam logic [3:0] ATTR_ILLEGAL = 4'hf;

    function automatic logic lvl_secure(input spsc_level_type l);
        return (l == LVL_S_ROOT_SUP) || (l == LVL_S_ROOT_USR);
    endfunction

    function automatic logic lvl_root(input spsc_level_type l);
        return (l == LVL_S_ROOT_SUP) || (l == LVL_S_ROOT_USR) ||
               (l == LVL_N_ROOT_SUP) || (l == LVL_N_ROOT_USR);
    endfunction

    function automatic logic lvl_sup(input spsc_level_type l);
        return (l == LVL_S_ROOT_SUP) || (l == LVL_N_ROOT_SUP) ||
               (l == LVL_N_GST_SUP);
    endfunction

endpackage

//--- hdl/spsc_micro_tlb.sv
// Fully associative micro-TLB with round-robin refill
`timescale 1ns/1ps
`default_nettype none
module spsc_micro_tlb import spsc_pkg::*; #(
    parameter int ENTRIES = TLB_ENTRIES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic flush_in,
    input wire spsc_tlb_fill_type fill_in,
    input wire logic [2:0] ctx_in,
    input wire logic [VPN_WIDTH-1:0] vpn_in,
    output logic hit_out,
    output spsc_tlb_fill_type entry_out
);
    localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

    spsc_tlb_fill_type ent_q [ENTRIES];
    logic [2:0] ctx_q [ENTRIES];
    logic [IW-1:0] ptr_q;
    logic [ENTRIES-1:0] match;

    // Entries are tagged with the level so contexts never alias
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_ent
            assign match[g] = ent_q[g].valid && ent_q[g].vpn == vpn_in &&
                              ctx_q[g] == ctx_in;
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ent_q[g] <= '0;
                    ctx_q[g] <= 3'h0;
                end else if (flush_in) begin
                    ent_q[g].valid <= 1'b0;
                end else if (fill_in.valid && ptr_q == IW'(g)) begin
                    ent_q[g] <= fill_in;
                    ctx_q[g] <= ctx_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_q <= '0;
        end else if (fill_in.valid) begin
            ptr_q <= (ptr_q == IW'(ENTRIES - 1)) ? '0 : ptr_q + 1'b1;
        end
    end

    always_comb begin
        hit_out = 1'b0;
        entry_out = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (match[i] && !hit_out) begin
                hit_out = 1'b1;
                entry_out = ent_q[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- test/spsc_mem_sink.sv
// Memory-system stand-in that takes and counts granted requests
`timescale 1ns/1ps
`default_nettype none
module spsc_mem_sink import spsc_pkg::*; (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire spsc_mem_req_type req_in,
    output logic [15:0] grants_out
);
    logic [15:0] grants_q;
    // Memory never stalls, so every granted request is taken at once
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            grants_q <= 16'h0000;
        end else if (req_in.valid) begin
            grants_q <= grants_q + 16'h0001;
        end
    end
    assign grants_out = grants_q;
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the security and privilege state control
`timescale 1ns/1ps
`default_nettype none
module tb import spsc_pkg::*;;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    spsc_event_type ev, ev_n;
    spsc_access_type acc, acc_n;
    spsc_tlb_fill_type fill, fill_n;
    logic flush, cwe, twe, iv, ins, inr, inu;
    logic [3:0] st_n;
    logic [CTRL_WIDTH-1:0] cwd, ctrl_rdata_out;
    logic [63:0] twd, ttb_out;
    spsc_level_type level_out;
    logic secure_out, instr_allow_out, fault_out;
    spsc_mem_req_type mem_req_out;
    spsc_fault_type fault_code_out;
    logic [15:0] grants;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 50713;
    int lvl = 0;
    int nreq = 0;
    int r, k, t;
    logic [CTRL_WIDTH-1:0] ctrl_m [NUM_LEVELS];
    logic [63:0] ttb_m [NUM_LEVELS];
    spsc_tlb_fill_type tlb_q [$];
    int tlb_l [$];

    always #50 clk_in = ~clk_in;

    spsc_state_ctrl dut_u (
        .clk_in(clk_in), .resetn_in(resetn_in), .event_in(ev),
        .access_in(acc), .tlb_fill_in(fill), .tlb_flush_in(flush),
        .ctrl_we_in(cwe), .ctrl_wdata_in(cwd), .ttb_we_in(twe),
        .ttb_wdata_in(twd), .instr_valid_in(iv),
        .instr_need_secure_in(ins), .instr_need_root_in(inr),
        .instr_need_sup_in(inu), .level_out(level_out),
        .secure_out(secure_out), .ctrl_rdata_out(ctrl_rdata_out),
        .ttb_out(ttb_out), .mem_req_out(mem_req_out),
        .instr_allow_out(instr_allow_out), .fault_out(fault_out),
        .fault_code_out(fault_code_out));

    spsc_mem_sink sink_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .req_in(mem_req_out), .grants_out(grants));

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Leaving a group only by return; entering one only by a handler or a call
    function automatic bit legal(input int c, input int k, input int t);
        if (k > 4 || t > 5) return 1'b0;
        if (k == 1) return (c % 2 == 0) && !(c > 1 && t < 2) &&
                           !(c > 3 && t < 4);
        if ((c < 2 && t > 1) || (c < 4 && t > 3)) return 1'b0;
        if (k == 3) return t == 0;
        if (c > 1 && t < 2) return k == 2 && t == 0;
        if (c > 3 && t < 4) return t == 2;
        return k == 2 || t < 4;
    endfunction

    function automatic bit allow(input int l);
        return (!ins || l < 2) && (!inr || l < 4) && (!inu || l % 2 == 0);
    endfunction

    task automatic tick();
        spsc_tlb_fill_type e;
        logic hit;
        int f;
        int ol;
        logic [PA_WIDTH-1:0] pa;
        {ev, acc, fill, flush, cwe, twe, iv} = {ev_n, acc_n, fill_n, st_n};
        {ev_n, acc_n, fill_n, st_n} = '0;
        hit = 1'b0;
        f = 0;
        ol = lvl;
        #5;
        if (iv) check("allow", instr_allow_out, allow(ol));
        @(posedge clk_in);
        #1;
        for (int i = 0; i < tlb_q.size(); i++) begin
            if (tlb_l[i] == ol && tlb_q[i].vpn == acc.vaddr[63:12]) begin
                hit = 1'b1;
                e = tlb_q[i];
            end
        end
        // A valid event with no kind changes nothing and is not refused
        if (ev.valid && ev.kind != EV_NONE &&
            !legal(ol, ev.kind, ev.target)) f = 5;
        else if (ev.valid && ev.kind != EV_NONE) lvl = ev.target;
        if (acc.valid && f == 0) begin
            if (!hit) f = 1;
            else if (e.secure && ol > 1) f = 2;
            else if ((ol % 2 == 1 && !e.user_ok) || (acc.write &&
                     !e.write_ok) || (acc.exec && !e.exec_ok)) f = 3;
            else if (e.attr == ATTR_ILLEGAL || (e.attr[3] && acc.exec)) f = 4;
            else pa = {e.ppn, acc.vaddr[11:0]};
        end
        if (iv && f == 0 && !acc.valid && !allow(ol)) f = 6;
        if (cwe) ctrl_m[ol] = cwd;
        if (twe) ttb_m[ol] = twd;
        if (fill.valid) tlb_q.push_back(fill);
        if (fill.valid) tlb_l.push_back(ol);
        // Round-robin refill keeps only the newest fills since a flush
        if (tlb_q.size() > TLB_ENTRIES) begin
            tlb_q.delete(0);
            tlb_l.delete(0);
        end
        if (flush) tlb_q.delete();
        if (flush) tlb_l.delete();
        check("level", level_out, lvl);
        check("secure", secure_out, lvl < 2);
        check("fault", fault_out, f != 0);
        if (f != 0) check("code", fault_code_out, f);
        check("grant", mem_req_out.valid, acc.valid && f == 0);
        if (acc.valid && f == 0) begin
            nreq++;
            check("paddr", mem_req_out.paddr, pa);
            check("msec", mem_req_out.secure, e.secure);
            check("wattr", {mem_req_out.write, mem_req_out.attr},
                  {acc.write, e.attr});
        end
        check("ctrl", ctrl_rdata_out, ctrl_m[lvl]);
        check("ttb", ttb_out, ttb_m[lvl]);
    endtask

    // Flag byte: secure, user, write, exec, then four attribute bits
    task automatic do_fill(input logic [51:0] v, input logic [7:0] g);
        fill_n = '{1'b1, v, v[27:0] ^ 28'h0abc000, g[7], g[6], g[5], g[4],
                   g[3:0]};
        tick();
    endtask

    task automatic do_acc(input logic [51:0] v, input logic w, input logic x);
        acc_n = '{1'b1, w, x, {v, r[11:0]}};
        tick();
    endtask

    task automatic do_bank();
        cwd = $random(seed);
        twd = {$random(seed), $random(seed)};
        st_n = 4'b0110;
        tick();
    endtask

    initial begin
        #5000000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {ev, acc, fill, flush, cwe, twe, iv} = '0;
        {ev_n, acc_n, fill_n, st_n} = '0;
        {ins, inr, inu, cwd, twd} = '0;
        r = $random(seed);
        for (int i = 0; i < NUM_LEVELS; i++) begin
            ctrl_m[i] = CTRL_RESET;
            ttb_m[i] = TTB_RESET;
        end
        repeat (6) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        tick();
        do_bank();
        do_fill(52'h1, 8'hf1);
        do_acc(52'h1, 1'b1, 1'b0);
        do_fill(52'h2, 8'h72);
        do_acc(52'h2, 1'b0, 1'b1);
        // Same-cycle return: access still judged at the secure level
        ev_n = '{1'b1, EV_RETURN, LVL_N_ROOT_SUP};
        do_acc(52'h1, 1'b0, 1'b0);
        do_bank();
        do_fill(52'h3, 8'hf1);
        do_acc(52'h3, 1'b0, 1'b0);
        do_fill(52'h4, 8'h51);
        do_acc(52'h4, 1'b1, 1'b0);
        do_fill(52'h5, 8'h7f);
        do_acc(52'h5, 1'b0, 1'b0);
        do_acc(52'h1, 1'b0, 1'b0);
        do_fill(52'h6, 8'h78);
        do_acc(52'h6, 1'b0, 1'b1);
        do_acc(52'h6, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            {ins, inr, inu} = i[2:0];
            st_n = 4'b0001;
            tick();
        end
        // Refused return blocks the access issued with it
        ev_n = '{1'b1, EV_RETURN, LVL_S_ROOT_SUP};
        do_acc(52'h4, 1'b0, 1'b0);
        st_n = 4'b1000;
        tick();
        do_acc(52'h4, 1'b0, 1'b0);
        // Nine fills in eight entries: the oldest one is evicted
        for (int j = 0; j < 9; j++) do_fill(52'h10 + 52'(j), 8'h71);
        do_acc(52'h10, 1'b0, 1'b0);
        do_acc(52'h18, 1'b0, 1'b0);
        // User level meets a supervisor-only page
        ev_n = '{1'b1, EV_RETURN, LVL_N_ROOT_USR};
        tick();
        do_fill(52'h20, 8'h31);
        do_acc(52'h20, 1'b0, 1'b0);
        for (int n = 0; n < 200; n++) begin
            r = $random(seed);
            // Now and then an undefined kind or level code
            k = r[14] ? r[9:7] : 1 + r[9:8];
            t = r[13] ? r[12:10] : r[12:10] % 6;
            {ins, inr, inu} = r[6:4];
            cwd = $random(seed);
            twd = {$random(seed), r};
            if (r[0]) ev_n = '{1'b1, spsc_event_kind_type'(k),
                               spsc_level_type'(t)};
            st_n = r[0] ? {3'b000, r[3]} : {1'b0, r[1], r[2], r[3]};
            tick();
        end
        check("grants", grants, nreq);
        print_verdict();
    end
endmodule
`default_nettype wire
